/* File: verilog/fpc_pkg.sv */
// Shared constants for the flash protection control block.
package fpc_pkg;

    // Register byte offsets on the register bus.
    localparam logic [7:0] FPC_OFS_BOOT_REGION = 8'h00;
    localparam logic [7:0] FPC_OFS_CODE_REGION = 8'h04;
    localparam logic [7:0] FPC_OFS_LOCK_CONFIG = 8'h08;
    localparam logic [7:0] FPC_OFS_WRITE_KEY = 8'h0C;
    localparam logic [7:0] FPC_OFS_STATUS = 8'h10;

    // Flash byte addresses: configuration bytes read out when reset ends, odd-byte erase range and program top.
    localparam logic [16:0] FPC_CFG_ADDR_FIRST = 17'h0E5FC;
    localparam logic [16:0] FPC_ODD_ERASE_LO = 17'h0E5F9;
    localparam logic [16:0] FPC_ODD_ERASE_HI = 17'h0E5FF;
    localparam logic [16:0] FPC_PROG_TOP = 17'h1FFFF;

    // Field positions and encodings.
    localparam int FPC_PAGE_SHIFT = 7;
    localparam logic [16:0] FPC_BOOT_TAIL = 17'h0000F;
    localparam logic [6:0] FPC_BOOT_NONE = 7'h7F;
    localparam logic [9:0] FPC_CODE_NONE = 10'h3FF;
    localparam int FPC_BLANK_MSB = 15;
    localparam int FPC_BLANK_LSB = 13;
    localparam int FPC_CODE_MSB = 9;
    localparam int FPC_WLOCK_LSB = 4;
    localparam logic [7:0] FPC_KEY_VALUE = 8'h6A;
    localparam logic [7:0] FPC_KEY_READ = 8'hFF;

    // Reset values of the configuration copies (most restrictive lock).
    localparam logic [7:0] FPC_RST_BOOT = 8'h00;
    localparam logic [15:0] FPC_RST_CODE = 16'h0000;
    localparam logic [7:0] FPC_RST_LOCK = 8'h00;

    // Bus responses.
    localparam logic [1:0] FPC_RESP_OKAY = 2'b00;
    localparam logic [1:0] FPC_RESP_SLVERR = 2'b10;

    // Core operation codes.
    typedef enum logic [1:0] {
        FPC_OP_READ,
        FPC_OP_WRITE,
        FPC_OP_ERASE,
        FPC_OP_MASS_ERASE
    } fpc_op_t;

    // Reset-time configuration sequencer.
    typedef enum logic [1:0] {
        FPC_CFG_WAIT_IDLE,
        FPC_CFG_REQUEST,
        FPC_CFG_WAIT_DATA,
        FPC_CFG_DONE
    } fpc_cfg_state_t;

endpackage

/* File: verilog/fpc_flash_protection_control.sv */
// Flash program memory protection, security and write key control.
//
// The AXI4-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps

module fpc_flash_protection_control
    import fpc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // AXI4-Lite register slave.
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Pins.
    input wire logic [1:0] i_env_select,
    input wire logic i_security_override_pin,
    // Core side program memory access.
    input wire logic i_core_req,
    input wire logic [1:0] i_core_op,
    input wire logic [16:0] i_core_addr,
    input wire logic [15:0] i_core_wdata,
    output logic o_core_blocked,
    output logic [15:0] o_core_rdata,
    output logic o_core_rvalid,
    output logic o_isp_environment,
    output logic o_reset_extend,
    // Flash array side.
    input wire logic i_flash_busy,
    output logic o_flash_abort,
    output logic o_flash_req,
    output logic [1:0] o_flash_op,
    output logic [16:0] o_flash_addr,
    output logic [15:0] o_flash_wdata,
    input wire logic [15:0] i_flash_rdata,
    input wire logic i_flash_rvalid,
    output logic o_cfg_rd_req,
    output logic [16:0] o_cfg_rd_addr,
    input wire logic [7:0] i_cfg_rd_data,
    input wire logic i_cfg_rd_valid
);

    // Decodes a 4-bit lock field; only all-zero or one-hot values enable it.
    function automatic logic lock_on(input logic [3:0] f);
        lock_on = (f == 4'h0) || (f == 4'h1) || (f == 4'h2) || (f == 4'h4) || (f == 4'h8);
    endfunction

    // Two-flop synchronisers for the asynchronous pins.
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {i_security_override_pin, i_env_select};
            pin_sync_q <= pin_meta_q;
        end
    end
    logic override_s;
    assign override_s = pin_sync_q[2];

    // Configuration sequencer state and copies.
    fpc_cfg_state_t cfg_state_q, cfg_state_d;
    logic [1:0] cfg_idx_q, cfg_idx_d;
    logic [7:0] boot_region_config_q, boot_region_config_d;
    logic [15:0] code_region_config_q, code_region_config_d;
    logic [7:0] flash_lock_config_q, flash_lock_config_d;
    logic isp_env_q, isp_env_d;
    logic abort_q, abort_d;
    logic extend_q, extend_d;
    logic cfg_req_q, cfg_req_d;
    logic [16:0] cfg_addr_q, cfg_addr_d;
    logic [2:0] blank_ind;

    assign blank_ind = code_region_config_q[FPC_BLANK_MSB:FPC_BLANK_LSB];

    // Reads E5FC..E5FF in turn once the flash has gone idle. Registers are
    // only written here, so software and later resets-free operation never
    // change them until the next reset reloads them.
    always_comb begin
        cfg_state_d = cfg_state_q;
        cfg_idx_d = cfg_idx_q;
        boot_region_config_d = boot_region_config_q;
        code_region_config_d = code_region_config_q;
        flash_lock_config_d = flash_lock_config_q;
        isp_env_d = isp_env_q;
        abort_d = abort_q;
        extend_d = extend_q;
        cfg_req_d = 1'b0;
        cfg_addr_d = cfg_addr_q;
        case (cfg_state_q)
            FPC_CFG_WAIT_IDLE: begin
                if (!i_flash_busy) begin
                    abort_d = 1'b0;
                    cfg_state_d = FPC_CFG_REQUEST;
                end
            end
            FPC_CFG_REQUEST: begin
                cfg_req_d = 1'b1;
                cfg_addr_d = FPC_CFG_ADDR_FIRST + {15'h0, cfg_idx_q};
                cfg_state_d = FPC_CFG_WAIT_DATA;
            end
            FPC_CFG_WAIT_DATA: begin
                if (i_cfg_rd_valid) begin
                    case (cfg_idx_q)
                        2'd0: code_region_config_d[7:0] = i_cfg_rd_data;
                        2'd1: boot_region_config_d = {1'b0, i_cfg_rd_data[6:0]};
                        2'd2: code_region_config_d[15:8] =
                            {i_cfg_rd_data[7:5], 3'b000, i_cfg_rd_data[1:0]};
                        default: flash_lock_config_d = i_cfg_rd_data;
                    endcase
                    cfg_idx_d = cfg_idx_q + 2'd1;
                    cfg_state_d = (cfg_idx_q == 2'd3) ? FPC_CFG_DONE : FPC_CFG_REQUEST;
                end
            end
            default: begin
                isp_env_d = (blank_ind == 3'b011 || blank_ind == 3'b101 || blank_ind[2:1] == 2'b11)
                    && (pin_sync_q[1:0] == 2'b11);
                extend_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_state_q <= FPC_CFG_WAIT_IDLE;
            cfg_idx_q <= 2'd0;
            boot_region_config_q <= FPC_RST_BOOT;
            code_region_config_q <= FPC_RST_CODE;
            flash_lock_config_q <= FPC_RST_LOCK;
            isp_env_q <= 1'b0;
            abort_q <= 1'b1;
            extend_q <= 1'b1;
            cfg_req_q <= 1'b0;
            cfg_addr_q <= 17'h0;
        end else begin
            cfg_state_q <= cfg_state_d;
            cfg_idx_q <= cfg_idx_d;
            boot_region_config_q <= boot_region_config_d;
            code_region_config_q <= code_region_config_d;
            flash_lock_config_q <= flash_lock_config_d;
            isp_env_q <= isp_env_d;
            abort_q <= abort_d;
            extend_q <= extend_d;
            cfg_req_q <= cfg_req_d;
            cfg_addr_q <= cfg_addr_d;
        end
    end

    // Protection decisions, derived from the reset-loaded copies and the override pin.
    logic rlock, wlock, ready;
    logic [6:0] boot_limit;
    logic [9:0] code_start;
    logic [16:0] boot_end, code_begin;
    logic in_boot, in_code, odd_cfg, wr_like, allowed, key_ok;
    fpc_op_t op;
    assign ready = (cfg_state_q == FPC_CFG_DONE) && !extend_q;
    assign op = fpc_op_t'(i_core_op);
    assign rlock = lock_on(flash_lock_config_q[FPC_WLOCK_LSB-1:0]) && !override_s;
    assign wlock = lock_on(flash_lock_config_q[7:FPC_WLOCK_LSB]) && !override_s;
    assign boot_limit = boot_region_config_q[6:0];
    assign code_start = code_region_config_q[FPC_CODE_MSB:0];
    assign boot_end = ({10'h0, boot_limit} << FPC_PAGE_SHIFT) + FPC_BOOT_TAIL;
    assign code_begin = {code_start, 7'h00};
    assign in_boot = (boot_limit != FPC_BOOT_NONE) && (i_core_addr <= boot_end);
    assign in_code = (code_start != FPC_CODE_NONE) && (i_core_addr >= code_begin)
        && (i_core_addr <= FPC_PROG_TOP);
    assign odd_cfg = i_core_addr[0] && (i_core_addr >= FPC_ODD_ERASE_LO)
        && (i_core_addr <= FPC_ODD_ERASE_HI);
    assign wr_like = (op == FPC_OP_WRITE) || (op == FPC_OP_ERASE);

    // Any single blocking condition is enough; the overlap of code and boot
    // areas is therefore covered by the boot test as well.
    always_comb begin
        allowed = 1'b1;
        if (op == FPC_OP_MASS_ERASE) begin
            allowed = !rlock && !wlock;
        end else if (wr_like) begin
            if (wlock || in_boot || in_code) begin
                allowed = 1'b0;
            end
            if (op == FPC_OP_ERASE && odd_cfg && rlock) begin
                allowed = 1'b0;
            end
            if (op == FPC_OP_WRITE && !key_ok) begin
                allowed = 1'b0;
            end
        end
    end

    // Core access path and write key status.
    logic key_set_q, key_set_d;
    logic freq_q, freq_d, blocked_q, blocked_d, rvalid_q, rvalid_d;
    logic [1:0] fop_q, fop_d;
    logic [16:0] faddr_q, faddr_d;
    logic [15:0] fwdata_q, fwdata_d, crdata_q, crdata_d;
    logic bus_write, key_write_good, core_take, rlock_rd;
    assign key_ok = key_set_q;
    assign core_take = i_core_req && ready;
    // Read masking does not depend on the override pin.
    assign rlock_rd = lock_on(flash_lock_config_q[FPC_WLOCK_LSB-1:0]);

    // The key is single-use: a core write or erase consumes it, and a key
    // write in the same cycle sets it again so that event is not lost.
    always_comb begin
        key_set_d = key_set_q;
        if ((core_take && op != FPC_OP_READ) || bus_write) begin
            key_set_d = 1'b0;
        end
        if (key_write_good) begin
            key_set_d = 1'b1;
        end
        freq_d = 1'b0;
        blocked_d = 1'b0;
        fop_d = fop_q;
        faddr_d = faddr_q;
        fwdata_d = fwdata_q;
        if (core_take) begin
            freq_d = allowed;
            blocked_d = !allowed;
            fop_d = i_core_op;
            faddr_d = i_core_addr;
            fwdata_d = i_core_wdata;
        end
        rvalid_d = i_flash_rvalid;
        crdata_d = (rlock_rd && isp_env_q) ? 16'h0000 : i_flash_rdata;
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            key_set_q <= 1'b0;
            freq_q <= 1'b0;
            blocked_q <= 1'b0;
            rvalid_q <= 1'b0;
            fop_q <= 2'h0;
            faddr_q <= 17'h0;
            fwdata_q <= 16'h0;
            crdata_q <= 16'h0;
        end else begin
            key_set_q <= key_set_d;
            freq_q <= freq_d;
            blocked_q <= blocked_d;
            rvalid_q <= rvalid_d;
            fop_q <= fop_d;
            faddr_q <= faddr_d;
            fwdata_q <= fwdata_d;
            crdata_q <= crdata_d;
        end
    end

    // AXI4-Lite slave: address and data are taken independently, then the
    // write takes effect and the response is raised together.
    logic awready_q, awready_d, wready_q, wready_d, aw_have_q, aw_have_d;
    logic w_have_q, w_have_d, bvalid_q, bvalid_d, arready_q, arready_d;
    logic rvalid_bus_q, rvalid_bus_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic do_write;

    assign do_write = aw_have_q && w_have_q && !bvalid_q;
    assign bus_write = do_write;
    assign key_write_good = do_write && (awaddr_q == FPC_OFS_WRITE_KEY) && wstrb_q[0]
        && (wdata_q[7:0] == FPC_KEY_VALUE);

    always_comb begin
        awready_d = i_awvalid && !awready_q && !aw_have_q && !bvalid_q;
        wready_d = i_wvalid && !wready_q && !w_have_q && !bvalid_q;
        aw_have_d = aw_have_q || (i_awvalid && awready_q);
        w_have_d = w_have_q || (i_wvalid && wready_q);
        awaddr_d = (i_awvalid && awready_q) ? i_awaddr : awaddr_q;
        wdata_d = (i_wvalid && wready_q) ? i_wdata : wdata_q;
        wstrb_d = (i_wvalid && wready_q) ? i_wstrb : wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (do_write) begin
            bvalid_d = 1'b1;
            if (awaddr_q == FPC_OFS_BOOT_REGION || awaddr_q == FPC_OFS_CODE_REGION
                || awaddr_q == FPC_OFS_LOCK_CONFIG || awaddr_q == FPC_OFS_WRITE_KEY
                || awaddr_q == FPC_OFS_STATUS) begin
                bresp_d = FPC_RESP_OKAY;
            end else begin
                bresp_d = FPC_RESP_SLVERR;
            end
        end else if (bvalid_q && i_bready) begin
            bvalid_d = 1'b0;
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
        end
        arready_d = i_arvalid && !arready_q && !rvalid_bus_q;
        rvalid_bus_d = rvalid_bus_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (i_arvalid && arready_q) begin
            rvalid_bus_d = 1'b1;
            rresp_d = FPC_RESP_OKAY;
            if (i_araddr == FPC_OFS_BOOT_REGION) begin
                rdata_d = {24'h0, boot_region_config_q};
            end else if (i_araddr == FPC_OFS_CODE_REGION) begin
                rdata_d = {16'h0, code_region_config_q};
            end else if (i_araddr == FPC_OFS_LOCK_CONFIG) begin
                rdata_d = {24'h0, flash_lock_config_q};
            end else if (i_araddr == FPC_OFS_WRITE_KEY) begin
                rdata_d = {24'h0, FPC_KEY_READ};
            end else if (i_araddr == FPC_OFS_STATUS) begin
                rdata_d = {26'h0, ready, override_s, lock_on(flash_lock_config_q[7:4]),
                    rlock_rd, isp_env_q, key_set_q};
            end else begin
                rdata_d = 32'h0;
                rresp_d = FPC_RESP_SLVERR;
            end
        end else if (rvalid_bus_q && i_rready) begin
            rvalid_bus_d = 1'b0;
        end
    end

    // Bus registers.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= FPC_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_bus_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= FPC_RESP_OKAY;
        end else begin
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_bus_q <= rvalid_bus_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Every output comes straight from a flip-flop.
    assign o_awready = awready_q;
    assign o_wready = wready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_bus_q;
    assign o_rdata = rdata_q;
    assign o_rresp = rresp_q;
    assign o_core_blocked = blocked_q;
    assign o_core_rdata = crdata_q;
    assign o_core_rvalid = rvalid_q;
    assign o_isp_environment = isp_env_q;
    assign o_reset_extend = extend_q;
    assign o_flash_abort = abort_q;
    assign o_flash_req = freq_q;
    assign o_flash_op = fop_q;
    assign o_flash_addr = faddr_q;
    assign o_flash_wdata = fwdata_q;
    assign o_cfg_rd_req = cfg_req_q;
    assign o_cfg_rd_addr = cfg_addr_q;

endmodule

/* File: test/fpc_flash_protection_control_chk.sv */
// Concurrent checks on the ports of the flash protection control block.
`timescale 1ns/100ps
module fpc_flash_protection_control_chk
    import fpc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_core_req,
    input wire logic [1:0] i_core_op,
    input wire logic [16:0] i_core_addr,
    input wire logic o_core_blocked,
    input wire logic o_flash_req,
    input wire logic [1:0] o_flash_op,
    input wire logic [16:0] o_flash_addr,
    input wire logic o_reset_extend,
    input wire logic o_flash_abort,
    input wire logic i_flash_busy,
    input wire logic i_flash_rvalid,
    input wire logic [15:0] i_flash_rdata,
    input wire logic o_core_rvalid,
    input wire logic [15:0] o_core_rdata,
    input wire logic o_isp_environment,
    input wire logic o_cfg_rd_req,
    input wire logic [16:0] o_cfg_rd_addr
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    // Core answers, read pass-through and the reset stretch around flash activity.
    a_core_answer: assert property (i_core_req && !o_reset_extend |=> o_flash_req != o_core_blocked)
        else $error("taken core request lacks a single answer");
    a_read_passes: assert property (i_core_req && !o_reset_extend && i_core_op == FPC_OP_READ |=> o_flash_req && o_flash_op == FPC_OP_READ)
        else $error("core read was not forwarded");
    a_fwd_addr: assert property (i_core_req && !o_reset_extend |=> !o_flash_req || o_flash_addr == $past(i_core_addr))
        else $error("forwarded address differs");
    a_rdata_pass: assert property (i_flash_rvalid && !o_isp_environment |=> o_core_rvalid && o_core_rdata == $past(i_flash_rdata))
        else $error("read data not returned in normal run");
    a_abort_busy: assert property (o_flash_abort && i_flash_busy |=> o_flash_abort)
        else $error("abort dropped while flash busy");
    a_abort_ext: assert property (o_flash_abort |-> o_reset_extend)
        else $error("reset stretch ended before flash idle");
    a_ext_quiet: assert property (o_reset_extend |=> !o_flash_req && !o_core_blocked)
        else $error("core request served during reset stretch");
    a_cfg_addr: assert property (o_cfg_rd_req |-> o_cfg_rd_addr >= FPC_CFG_ADDR_FIRST && o_cfg_rd_addr <= FPC_ODD_ERASE_HI)
        else $error("configuration read outside reserved bytes");
endmodule

bind fpc_flash_protection_control fpc_flash_protection_control_chk chk_u (
    .i_clk_sys, .i_resetn, .i_core_req, .i_core_op, .i_core_addr, .o_core_blocked,
    .o_flash_req, .o_flash_op, .o_flash_addr, .o_reset_extend, .o_flash_abort,
    .i_flash_busy, .i_flash_rvalid, .i_flash_rdata, .o_core_rvalid, .o_core_rdata,
    .o_isp_environment, .o_cfg_rd_req, .o_cfg_rd_addr
);

/* File: test/fpc_flash_model.sv */
// Behavioural flash array answering configuration and program reads.
`timescale 1ns/100ps
module fpc_flash_model
    import fpc_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_slow,
    input wire logic [31:0] i_cfg,
    input wire logic i_cfg_req,
    input wire logic [16:0] i_cfg_addr,
    output logic [7:0] o_cfg_data,
    output logic o_cfg_valid,
    input wire logic i_req,
    input wire logic [1:0] i_op,
    input wire logic [16:0] i_addr,
    output logic [15:0] o_rdata,
    output logic o_rvalid,
    output logic o_busy
);
    logic [1:0] wait_q = 2'h0;
    logic [1:0] sel_q = 2'h0;
    logic [4:0] busy_q = 5'h00;

    initial begin
        o_cfg_data = 8'h00;
        o_rdata = 16'h0000;
    end

    // Answers after one or three cycles; idle data shows the inverse so stale reads show.
    // flash stays busy
    always @(posedge i_clk_sys) begin
        o_cfg_valid <= 1'b0;
        o_rvalid <= 1'b0;
        o_cfg_data <= ~o_cfg_data;
        o_rdata <= ~o_rdata;
        if (i_cfg_req) begin
            wait_q <= i_slow ? 2'h3 : 2'h1;
            sel_q <= i_cfg_addr[1:0];
        end else if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
        end
        if (wait_q == 2'h1) begin
            o_cfg_valid <= 1'b1;
            o_cfg_data <= i_cfg[8*sel_q +: 8];
        end
        if (i_req && i_op == FPC_OP_READ) begin
            o_rvalid <= 1'b1;
            o_rdata <= i_addr[15:0] ^ 16'h5A5A;
        end
        if (i_req && i_op != FPC_OP_READ) begin
            busy_q <= 5'h14;
        end else if (busy_q != 5'h00) begin
            busy_q <= busy_q - 5'h01;
        end
    end
    assign o_busy = busy_q != 5'h00;
endmodule

/* File: test/fpc_flash_protection_control_tb.sv */
// Self-checking bench for the flash protection control block.
`timescale 1ns/100ps
module fpc_flash_protection_control_tb import fpc_pkg::*;;
    logic i_clk_sys, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, slow;
    logic i_security_override_pin, i_core_req, o_awready, o_wready, o_bvalid, o_arready;
    logic o_rvalid, o_core_blocked, o_core_rvalid, o_isp_environment, o_reset_extend;
    logic i_flash_busy, o_flash_abort, o_flash_req, i_flash_rvalid, o_cfg_rd_req;
    logic i_cfg_rd_valid;
    logic [7:0] i_awaddr, i_araddr, i_cfg_rd_data;
    logic [31:0] i_wdata, o_rdata, cfg_bytes;
    logic [3:0] i_wstrb;
    logic [1:0] i_env_select, i_core_op, o_bresp, o_rresp, o_flash_op;
    logic [16:0] i_core_addr, o_flash_addr, o_cfg_rd_addr;
    logic [15:0] i_core_wdata, o_core_rdata, o_flash_wdata, i_flash_rdata;
    int n_mismatch, n_tests;

    fpc_flash_protection_control dut_u (
        .i_clk_sys, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
        .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
        .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_env_select,
        .i_security_override_pin, .i_core_req, .i_core_op, .i_core_addr, .i_core_wdata,
        .o_core_blocked, .o_core_rdata, .o_core_rvalid, .o_isp_environment, .o_reset_extend,
        .i_flash_busy, .o_flash_abort, .o_flash_req, .o_flash_op, .o_flash_addr,
        .o_flash_wdata, .i_flash_rdata, .i_flash_rvalid, .o_cfg_rd_req, .o_cfg_rd_addr,
        .i_cfg_rd_data, .i_cfg_rd_valid
    );

    fpc_flash_model flash_u (
        .i_clk_sys(i_clk_sys), .i_slow(slow), .i_cfg(cfg_bytes), .i_cfg_req(o_cfg_rd_req),
        .i_cfg_addr(o_cfg_rd_addr), .o_cfg_data(i_cfg_rd_data), .o_cfg_valid(i_cfg_rd_valid),
        .i_req(o_flash_req), .i_op(o_flash_op), .i_addr(o_flash_addr),
        .o_rdata(i_flash_rdata), .o_rvalid(i_flash_rvalid), .o_busy(i_flash_busy)
    );

    // The 25 MHz system clock.
    initial begin
        i_clk_sys = 1'b0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Both channels are offered together; the response is taken at the bvalid edge.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clk_sys);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid);
        i_bready <= 1'b0;
        chk(32'(o_bresp), 32'(er));
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge i_clk_sys);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk_sys);
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid);
        i_rready <= 1'b0;
        chk(o_rdata, ed);
        chk(32'(o_rresp), 32'(er));
    endtask

    // One core request; the answer stands in the following cycle only.
    task automatic core(input logic [1:0] op, input logic [16:0] a, input logic ok);
        @(posedge i_clk_sys);
        i_core_req <= 1'b1;
        i_core_op <= op;
        i_core_addr <= a;
        i_core_wdata <= a[15:0];
        @(posedge i_clk_sys);
        i_core_req <= 1'b0;
        #1;
        chk(32'({o_flash_req, o_core_blocked}), 32'({ok, !ok}));
    endtask

    task automatic kw(input logic [16:0] a, input logic ok);
        axi_wr(FPC_OFS_WRITE_KEY, 32'(FPC_KEY_VALUE), FPC_RESP_OKAY);
        core(FPC_OP_WRITE, a, ok);
        if (ok) chk(32'(o_flash_wdata), 32'(a[15:0]));
    endtask

    task automatic core_rd(input logic [16:0] a, input logic [15:0] e);
        core(FPC_OP_READ, a, 1'b1);
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk(32'({o_core_rvalid, o_core_rdata}), 32'({1'b1, e}));
    endtask

    // Reset for ten cycles with new flash bytes, then wait for the stretch to end.
    task automatic do_reset(input logic [31:0] c, input logic s, input logic ea);
        @(posedge i_clk_sys);
        i_resetn <= 1'b0;
        cfg_bytes <= c;
        slow <= s;
        repeat (10) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        #1;
        if (ea) chk(32'(o_flash_abort), 32'h1);
        while (o_reset_extend !== 1'b0) begin
            @(posedge i_clk_sys);
        end
        #1;
    endtask

    // Two configurations: locks off with both regions set, then locks on in programming mode.
    initial begin
        {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_core_req} = '0;
        {i_awaddr, i_araddr, i_wdata, i_core_op, i_core_addr, i_core_wdata} = '0;
        {i_security_override_pin, slow, n_mismatch, n_tests} = '0;
        i_wstrb = 4'hF;
        i_env_select = 2'b11;
        cfg_bytes = 32'h3C02_0100;
        do_reset(32'h3C02_0100, 1'b0, 1'b0);
        chk(32'(o_isp_environment), 32'h0);
        axi_rd(FPC_OFS_BOOT_REGION, 32'h01, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_CODE_REGION, 32'h0200, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_LOCK_CONFIG, 32'h3C, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_WRITE_KEY, 32'hFF, FPC_RESP_OKAY);
        axi_rd(8'h14, 32'h0, FPC_RESP_SLVERR);
        axi_wr(FPC_OFS_BOOT_REGION, 32'h7F, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_BOOT_REGION, 32'h01, FPC_RESP_OKAY);
        core(FPC_OP_WRITE, 17'h00090, 1'b0);
        kw(17'h0008F, 1'b0);
        kw(17'h00090, 1'b1);
        axi_wr(FPC_OFS_WRITE_KEY, 32'(FPC_KEY_VALUE), FPC_RESP_OKAY);
        kw(17'h00100, 1'b1);
        axi_wr(FPC_OFS_WRITE_KEY, 32'(FPC_KEY_VALUE), FPC_RESP_OKAY);
        axi_wr(FPC_OFS_STATUS, 32'h0, FPC_RESP_OKAY);
        core(FPC_OP_WRITE, 17'h00100, 1'b0);
        kw(17'h10000, 1'b0);
        kw(17'h0FFFF, 1'b1);
        core(FPC_OP_ERASE, 17'h0E5F9, 1'b1);
        core(FPC_OP_MASS_ERASE, 17'h00000, 1'b1);
        core_rd(17'h00123, 16'h5B79);
        kw(17'h00200, 1'b1);
        axi_wr(FPC_OFS_WRITE_KEY, 32'(FPC_KEY_VALUE), FPC_RESP_OKAY);
        do_reset(32'h18C3_7FFF, 1'b1, 1'b1);
        chk(32'(o_isp_environment), 32'h1);
        axi_rd(FPC_OFS_STATUS, 32'h2E, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_CODE_REGION, 32'hC3FF, FPC_RESP_OKAY);
        axi_rd(FPC_OFS_LOCK_CONFIG, 32'h18, FPC_RESP_OKAY);
        core_rd(17'h00040, 16'h0000);
        kw(17'h01000, 1'b0);
        core(FPC_OP_ERASE, 17'h0E5F9, 1'b0);
        core(FPC_OP_MASS_ERASE, 17'h00000, 1'b0);
        i_security_override_pin <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        core(FPC_OP_MASS_ERASE, 17'h00000, 1'b1);
        core(FPC_OP_WRITE, 17'h00000, 1'b0);
        kw(17'h00000, 1'b1);
        kw(17'h1FF80, 1'b1);
        core_rd(17'h00040, 16'h0000);
        test_done;
    end

    // A hang ends the run after well over the expected few hundred cycles.
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        n_mismatch++;
        test_done;
    end
endmodule
